//--- verilog/nmds_consts.svh
// Constants for the multi-die NAND host sequencer
`ifndef NMDS_CONSTS_SVH
`define NMDS_CONSTS_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define NMDS_CLK_NS 20
`define NMDS_T_WP_NS 15
`define NMDS_T_WH_NS 10
`define NMDS_T_REA_NS 20
`define NMDS_SYNC_CYC 2
`define NMDS_CYC(ns) (((ns) + `NMDS_CLK_NS - 1) / `NMDS_CLK_NS)
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define NMDS_OFS_CTRL 8'h00
`define NMDS_OFS_STAT 8'h04
`define NMDS_OFS_RDAT 8'h08
`define NMDS_OFS_ROW 8'h0C
`define NMDS_OFS_ROW2 8'h10
`define NMDS_OFS_FLAG 8'h14
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define NMDS_OP_RESET 8'hFF
`define NMDS_OP_RDID 8'h90
`define NMDS_OP_PARAM 8'hEC
`define NMDS_OP_UID 8'hED
`define NMDS_OP_GETF 8'hEE
`define NMDS_OP_SETF 8'hEF
`define NMDS_OP_STATE 8'h78
`define NMDS_OP_STAT 8'h70
`define NMDS_OP_PROG 8'h80
`define NMDS_OP_PGO 8'h10
`define NMDS_OP_PCACHE 8'h15
`define NMDS_OP_RGO 8'h30
`define NMDS_OP_EGO 8'hD0
// ----------------------------------------
// Fields
// ----------------------------------------
`define NMDS_SR_RDY 6
`define NMDS_SR_ARRAY_READY_FLAG 5
`define NMDS_SR_E4 4
`define NMDS_SR_E3 3
`define NMDS_SR_E0 0
`define NMDS_ECC_UNC 3'h1
`define NMDS_ECC_MID 3'h2
`define NMDS_ECC_HIGH 3'h6
`define NMDS_ERASED 8'hFF
`define NMDS_PG_LSB 0
`define NMDS_PG_W 6
`define NMDS_PLANE 6
`define NMDS_BLK_LSB 6
`define NMDS_BLK_W 11
`define NMDS_DIE_LSB 17
`define NMDS_FL_REFUSED 0
`define NMDS_FL_REC 1
`define NMDS_FL_REQ 2
`define NMDS_FL_UNC 3
`define NMDS_FL_BAD 4
`define NMDS_FL_W 5
`define NMDS_ST_RDY_LSB 8
`define NMDS_ST_ARRAY_READY_FLAG_LSB 16
`endif

//--- verilog/nmds_pkg.sv
// Types shared by the multi-die NAND host sequencer
package nmds_pkg;
	// Kind of one bus cycle on the NAND pins
	typedef enum logic [1:0] {K_CMD, K_ADDR, K_WDAT, K_RDAT} nmds_kind_e;
	// Pin engine states
	typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD} nmds_state_e;
	// Driven NAND pins
	typedef struct packed {
		logic ce_b;
		logic cle;
		logic ale;
		logic we_b;
		logic re_b;
		logic [7:0] io;
		logic io_oe;
	} nmds_pins_s;
	// One request written to the control register
	typedef struct packed {
		logic tp;
		logic rd_last;
		logic spare;
		nmds_kind_e kind;
		logic [7:0] val;
	} nmds_req_s;
endpackage

//--- verilog/nmds_host.sv
// Host sequencer driving a multi-die NAND target through its pins
// Contract
// - Start work only on a ready die
// - No interleaving after init until all ready
// - Enhanced status polls one addressed die
// - Plain status banned around interleaving
// - Two-plane limits still hold when interleaving
// - Program series goes before read series
// - Read data out before next program
// - Refresh data on mid or high corrections
// - Host maps out initial bad blocks
// - Two-plane: same die, page; plane differs
// - Never program or erase bad blocks; the code checks only the row block, not row2, against the table
`include "nmds_consts.svh"
module nmds_host #(
	parameter int DIES = 2,
	parameter int NBAD = 4
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// AXI4-Lite write channels
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [7:0] i_awaddr,
	input wire logic i_wvalid,
	output logic o_wready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	output logic o_bvalid,
	input wire logic i_bready,
	output logic [1:0] o_bresp,
	// AXI4-Lite read channels
	input wire logic i_arvalid,
	output logic o_arready,
	input wire logic [7:0] i_araddr,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	// NAND pins
	output nmds_pkg::nmds_pins_s o_pins,
	input wire logic [7:0] i_io,
	input wire logic i_rb
);
	// DIES must be at least 2 so the die index has a width
	localparam int DW = $clog2(DIES);
	localparam logic [3:0] WP_CYC = 4'(`NMDS_CYC(`NMDS_T_WP_NS));
	localparam logic [3:0] WH_CYC = 4'(`NMDS_CYC(`NMDS_T_WH_NS));
	localparam logic [3:0] RD_CYC = 4'(`NMDS_CYC(`NMDS_T_REA_NS) + `NMDS_SYNC_CYC);

	// ----------------------------------------
	// Decoding helpers
	// ----------------------------------------
	function automatic logic is_start(input logic [7:0] v);
		return v == `NMDS_OP_PGO || v == `NMDS_OP_PCACHE || v == `NMDS_OP_RGO ||
			v == `NMDS_OP_EGO;
	endfunction
	function automatic logic is_init(input logic [7:0] v);
		return v == `NMDS_OP_RESET || v == `NMDS_OP_RDID || v == `NMDS_OP_PARAM ||
			v == `NMDS_OP_UID || v == `NMDS_OP_GETF || v == `NMDS_OP_SETF;
	endfunction
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = n[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	nmds_pkg::nmds_state_e st;
	nmds_pkg::nmds_req_s cur;
	nmds_pkg::nmds_req_s nreq;
	nmds_pkg::nmds_pins_s pins;
	logic [3:0] cnt;
	logic rd_done;
	logic [7:0] rdq;
	logic [7:0] io_s1, io_s2;
	logic rb_s1, rb_s2, rb_s3;
	logic [31:0] row, row2;
	logic [DIES-1:0] die_rdy, die_array_ready_flag, die_rd;
	logic block_il, il_seen, read_pending, poll_pend, stat_pend;
	logic [DW-1:0] pdie;
	logic [`NMDS_FL_W-1:0] flags;
	logic [`NMDS_BLK_W-1:0] bad_blk [NBAD];
	logic [NBAD-1:0] bad_vld;
	logic bvalid, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Async pins pass two flops before any logic looks at them
	// Busy pin chain starts at its idle level, so leaving reset makes no false rising edge
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			io_s1 <= 8'h00;
			io_s2 <= 8'h00;
			rb_s1 <= 1'b1;
			rb_s2 <= 1'b1;
			rb_s3 <= 1'b1;
		end else begin
			io_s1 <= i_io;
			io_s2 <= io_s1;
			rb_s1 <= i_rb;
			rb_s2 <= rb_s1;
			rb_s3 <= rb_s2;
		end
	end

	// ----------------------------------------
	// Request decode and checks
	// ----------------------------------------
	logic aw_ok, wr_ctrl, go, is_cmd, refuse_c, other_busy, plane_ok, bad_hit, rb_rise;
	logic [DW-1:0] cdie;
	logic [DIES-1:0] dmask;
	logic [7:0] v;
	assign nreq = nmds_pkg::nmds_req_s'(i_wdata[$bits(nmds_pkg::nmds_req_s)-1:0]);
	assign v = nreq.val;
	assign is_cmd = nreq.kind == nmds_pkg::K_CMD;
	assign aw_ok = i_awvalid && i_wvalid && !bvalid;
	assign wr_ctrl = aw_ok && i_awaddr == `NMDS_OFS_CTRL && i_wstrb[0];
	assign cdie = row[`NMDS_DIE_LSB +: DW];
	assign dmask = DIES'(1) << cdie;
	assign other_busy = |(~die_array_ready_flag & ~dmask);
	assign rb_rise = rb_s2 && !rb_s3;
	// Both plane addresses sit on one die and page, on opposite planes
	assign plane_ok = row[`NMDS_DIE_LSB +: DW] == row2[`NMDS_DIE_LSB +: DW] &&
		row[`NMDS_PG_LSB +: `NMDS_PG_W] == row2[`NMDS_PG_LSB +: `NMDS_PG_W] &&
		row[`NMDS_PLANE] != row2[`NMDS_PLANE];
	// Table lookup for a block already known to be bad
	always_comb begin
		bad_hit = 1'b0;
		for (int i = 0; i < NBAD; i++) begin
			if (bad_vld[i] && bad_blk[i] == row[`NMDS_BLK_LSB +: `NMDS_BLK_W]) begin
				bad_hit = 1'b1;
			end
		end
	end
	// A refused request leaves the pins alone and raises the refused flag
	assign refuse_c = is_cmd && (
		(is_start(v) && (!die_rdy[cdie] ||
		(block_il && other_busy) ||
		(nreq.tp && !plane_ok) ||
		(v != `NMDS_OP_RGO && bad_hit))) ||
		(v == `NMDS_OP_STAT && il_seen) ||
		(v == `NMDS_OP_PROG && (read_pending || |die_rd)));
	assign go = wr_ctrl && st == nmds_pkg::ST_IDLE && !refuse_c;

	// ----------------------------------------
	// Pin engine
	// ----------------------------------------
	// Setup, strobe low, strobe high; read data sampled after the sync delay
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st <= nmds_pkg::ST_IDLE;
			cnt <= 4'h0;
			cur <= '0;
			rd_done <= 1'b0;
			rdq <= 8'h00;
			pins.ce_b <= 1'b1;
			pins.cle <= 1'b0;
			pins.ale <= 1'b0;
			pins.we_b <= 1'b1;
			pins.re_b <= 1'b1;
			pins.io <= 8'h00;
			pins.io_oe <= 1'b0;
		end else begin
			rd_done <= 1'b0;
			unique case (st)
				nmds_pkg::ST_IDLE: begin
					if (go) begin
						cur <= nreq;
						st <= nmds_pkg::ST_SETUP;
						pins.ce_b <= 1'b0;
						pins.cle <= is_cmd;
						pins.ale <= nreq.kind == nmds_pkg::K_ADDR;
						pins.io <= v;
						pins.io_oe <= nreq.kind != nmds_pkg::K_RDAT;
					end
				end
				nmds_pkg::ST_SETUP: begin
					st <= nmds_pkg::ST_PULSE;
					cnt <= (cur.kind == nmds_pkg::K_RDAT) ? RD_CYC : WP_CYC;
					pins.we_b <= cur.kind == nmds_pkg::K_RDAT;
					pins.re_b <= cur.kind != nmds_pkg::K_RDAT;
				end
				nmds_pkg::ST_PULSE: begin
					if (cnt == 4'h1) begin
						st <= nmds_pkg::ST_HOLD;
						cnt <= WH_CYC;
						pins.we_b <= 1'b1;
						pins.re_b <= 1'b1;
						if (cur.kind == nmds_pkg::K_RDAT) begin
							rdq <= io_s2;
							rd_done <= 1'b1;
						end
					end else begin
						cnt <= cnt - 4'h1;
					end
				end
				nmds_pkg::ST_HOLD: begin
					if (cnt == 4'h1) begin
						st <= nmds_pkg::ST_IDLE;
						pins.ce_b <= 1'b1;
						pins.cle <= 1'b0;
						pins.ale <= 1'b0;
						pins.io_oe <= 1'b0;
					end else begin
						cnt <= cnt - 4'h1;
					end
				end
			endcase
		end
	end
	assign o_pins = pins;

	// ----------------------------------------
	// Die tracking
	// ----------------------------------------
	// Newest event wins: a start beats a stale idle edge on the busy pin,
	// and an idle edge beats a poll byte that was sampled a cycle before it
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			die_rdy <= '0;
			die_array_ready_flag <= '0;
			block_il <= 1'b1;
		end else begin
			if (go && is_cmd && is_start(v)) begin
				die_rdy[cdie] <= 1'b0;
				die_array_ready_flag[cdie] <= 1'b0;
			end else if (go && is_cmd && v == `NMDS_OP_RESET) begin
				die_rdy <= '0;
				die_array_ready_flag <= '0;
			end else if (rb_rise) begin
				die_rdy <= '1;
				die_array_ready_flag <= '1;
			end else if (rd_done && poll_pend) begin
				die_rdy[pdie] <= rdq[`NMDS_SR_RDY];
				die_array_ready_flag[pdie] <= rdq[`NMDS_SR_ARRAY_READY_FLAG];
			end
			if (go && is_cmd && is_init(v)) begin
				block_il <= 1'b1;
			end else if (&die_array_ready_flag) begin
				block_il <= 1'b0;
			end
		end
	end

	// Interleave, read ordering and status-read bookkeeping
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			il_seen <= 1'b0;
			read_pending <= 1'b0;
			die_rd <= '0;
			poll_pend <= 1'b0;
			stat_pend <= 1'b0;
			pdie <= '0;
		end else begin
			die_rd <= die_rd & ~die_array_ready_flag;
			if (go && is_cmd && is_start(v) && other_busy) begin
				il_seen <= 1'b1;
			end else if (go && is_cmd && v == `NMDS_OP_RESET) begin
				il_seen <= 1'b0;
			end
			if (go && is_cmd && v == `NMDS_OP_RGO) begin
				read_pending <= 1'b1;
				die_rd <= (die_rd & ~die_array_ready_flag) | dmask;
			end else if (rd_done && cur.rd_last && !stat_pend) begin
				read_pending <= 1'b0;
			end
			if (go && is_cmd && (v == `NMDS_OP_STATE || v == `NMDS_OP_STAT)) begin
				stat_pend <= 1'b1;
				poll_pend <= v == `NMDS_OP_STATE;
				pdie <= cdie;
			end else if (rd_done) begin
				stat_pend <= 1'b0;
				poll_pend <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Bad block table
	// ----------------------------------------
	// Newest entry shifts in; the oldest falls out when the table is full
	logic bad_seen;
	assign bad_seen = rd_done && cur.spare && !stat_pend && rdq != `NMDS_ERASED;
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			bad_vld <= '0;
			for (int i = 0; i < NBAD; i++) begin
				bad_blk[i] <= '0;
			end
		end else if (bad_seen) begin
			bad_vld <= {bad_vld[NBAD-2:0], 1'b1};
			bad_blk[0] <= row[`NMDS_BLK_LSB +: `NMDS_BLK_W];
			for (int i = 1; i < NBAD; i++) begin
				bad_blk[i] <= bad_blk[i-1];
			end
		end
	end

	// ----------------------------------------
	// Sticky flags
	// ----------------------------------------
	logic [2:0] ecc;
	logic [`NMDS_FL_W-1:0] fset, fclr;
	assign ecc = {rdq[`NMDS_SR_E4], rdq[`NMDS_SR_E3], rdq[`NMDS_SR_E0]};
	always_comb begin
		fset = '0;
		fset[`NMDS_FL_REFUSED] = wr_ctrl && (st != nmds_pkg::ST_IDLE || refuse_c);
		fset[`NMDS_FL_REC] = rd_done && stat_pend && ecc == `NMDS_ECC_MID;
		fset[`NMDS_FL_REQ] = rd_done && stat_pend && ecc == `NMDS_ECC_HIGH;
		fset[`NMDS_FL_UNC] = rd_done && stat_pend && ecc == `NMDS_ECC_UNC;
		fset[`NMDS_FL_BAD] = bad_seen;
		fclr = '0;
		if (aw_ok && i_awaddr == `NMDS_OFS_FLAG && i_wstrb[0]) begin
			fclr = i_wdata[`NMDS_FL_W-1:0];
		end
	end
	// Set beats a clear in the same cycle so no event is lost
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			flags <= '0;
		end else begin
			flags <= (flags & ~fclr) | fset;
		end
	end

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	function automatic logic mapped(input logic [7:0] a);
		return a == `NMDS_OFS_CTRL || a == `NMDS_OFS_STAT || a == `NMDS_OFS_RDAT ||
			a == `NMDS_OFS_ROW || a == `NMDS_OFS_ROW2 || a == `NMDS_OFS_FLAG;
	endfunction
	assign o_awready = aw_ok;
	assign o_wready = aw_ok;
	assign o_arready = !rvalid;
	assign o_bvalid = bvalid;
	assign o_bresp = bresp;
	assign o_rvalid = rvalid;
	assign o_rresp = rresp;
	assign o_rdata = rdata;
	// Write: address and data taken together, answer one cycle later
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			bvalid <= 1'b0;
			bresp <= 2'h0;
			row <= 32'h0000_0000;
			row2 <= 32'h0000_0000;
		end else begin
			if (aw_ok) begin
				bvalid <= 1'b1;
				bresp <= mapped(i_awaddr) ? 2'h0 : 2'h2;
				if (i_awaddr == `NMDS_OFS_ROW) begin
					row <= merge(row, i_wdata, i_wstrb);
				end
				if (i_awaddr == `NMDS_OFS_ROW2) begin
					row2 <= merge(row2, i_wdata, i_wstrb);
				end
			end else if (i_bready) begin
				bvalid <= 1'b0;
			end
		end
	end
	// Read mux
	logic [31:0] rd_val;
	always_comb begin
		rd_val = 32'h0000_0000;
		unique case (i_araddr)
			`NMDS_OFS_CTRL: rd_val = 32'(cur);
			`NMDS_OFS_STAT: rd_val = {26'h0, plane_ok, rb_s2, read_pending, il_seen,
				block_il, st != nmds_pkg::ST_IDLE} |
				(32'(die_rdy) << `NMDS_ST_RDY_LSB) | (32'(die_array_ready_flag) << `NMDS_ST_ARRAY_READY_FLAG_LSB);
			`NMDS_OFS_RDAT: rd_val = 32'(rdq);
			`NMDS_OFS_ROW: rd_val = row;
			`NMDS_OFS_ROW2: rd_val = row2;
			`NMDS_OFS_FLAG: rd_val = 32'(flags);
			default: rd_val = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rvalid <= 1'b0;
			rresp <= 2'h0;
			rdata <= 32'h0000_0000;
		end else if (i_arvalid && !rvalid) begin
			rvalid <= 1'b1;
			rresp <= mapped(i_araddr) ? 2'h0 : 2'h2;
			rdata <= rd_val;
		end else if (i_rready) begin
			rvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	sequence s_cmd_go;
		go && is_cmd;
	endsequence
	sequence s_cmd_strobe;
		##1 (pins.cle && pins.we_b && !pins.ce_b) ##1 !pins.we_b ##1 pins.we_b;
	endsequence
	a_cmd_strobe_shape: assert property (s_cmd_go |-> s_cmd_strobe)
		else $error("command strobe shape wrong");
	a_start_ready_die: assert property (s_cmd_go and is_start(v) |-> die_rdy[cdie])
		else $error("start issued to busy die");
	a_init_no_interleave: assert property (
		go && is_cmd && is_start(v) && block_il |-> !other_busy)
		else $error("interleave after init before all ready");
	a_rb_all_idle: assert property (rb_rise && !go |=> &die_array_ready_flag)
		else $error("busy pin idle not reflected");
	a_poll_one_die: assert property (
		rd_done && poll_pend && !go && !rb_rise |=>
		die_array_ready_flag[$past(pdie)] == $past(rdq[`NMDS_SR_ARRAY_READY_FLAG]))
		else $error("enhanced poll not applied to its die");
	a_no_plain_stat: assert property (
		go && is_cmd && v == `NMDS_OP_STAT |-> !il_seen)
		else $error("plain status during interleave");
	a_plane_addr: assert property (go && is_cmd && is_start(v) && nreq.tp |-> plane_ok)
		else $error("two-plane addresses illegal");
	a_prog_order: assert property (
		go && is_cmd && v == `NMDS_OP_PROG |-> !read_pending && die_rd == '0)
		else $error("program setup before read data out");
	a_ecc_refresh: assert property (
		rd_done && stat_pend && ecc == `NMDS_ECC_HIGH |=> flags[`NMDS_FL_REQ])
		else $error("required refresh not flagged");
	a_bad_block: assert property (
		go && is_cmd && is_start(v) && v != `NMDS_OP_RGO |-> !bad_hit)
		else $error("program or erase on bad block");
endmodule // nmds_host

//--- dv/nmds_nand_model.sv
// Behavioural two-die NAND target answering the host sequencer's pins
module nmds_nand_model #(
	parameter int BUSY = 400
) (
	// Host pins and injected ECC outcome
	input wire logic i_clk,
	input wire nmds_pkg::nmds_pins_s i_pins,
	input wire logic [2:0] i_ecc,
	// Data and busy back to the host
	output logic [7:0] o_io,
	output logic o_rb
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt [2] = '{0, 0};
	int rcnt [2] = '{0, 0};
	int na = 0;
	logic [7:0] cmd = 8'h00;
	logic [7:0] colh = 8'h00;
	logic [7:0] row1 = 8'h00;
	logic [7:0] tog = 8'h5A;
	logic [7:0] st;
	logic [1:0] rdy;
	logic [1:0] array_ready_flag;
	logic die = 1'b0;
	logic held = 1'b0;
	logic pwe = 1'b1;
	logic wlat;
	assign wlat = !pwe && i_pins.we_b && !i_pins.ce_b;
	// Latch commands and addresses on the rising write strobe
	always @(posedge i_clk) begin
		pwe <= i_pins.we_b;
		tog <= ~tog;
		for (int d = 0; d < 2; d++) begin
			if (cnt[d] > 0) cnt[d] <= cnt[d] - 1;
			if (rcnt[d] > 0) rcnt[d] <= rcnt[d] - 1;
		end
		if (wlat && i_pins.cle) begin
			cmd <= i_pins.io;
			na <= 0;
			case (i_pins.io)
				8'hFF: begin
					cnt <= '{BUSY, 2 * BUSY}; // Second die is slower, so init can be seen half done
					rcnt <= '{BUSY, 2 * BUSY};
				end
				8'h10, 8'h30, 8'hD0: begin
					cnt[die] <= BUSY;
					rcnt[die] <= BUSY;
				end
				8'h15: begin
					cnt[die] <= 2 * BUSY; // Array work outlasts cache readiness
					rcnt[die] <= BUSY / 4;
				end
				default: ;
			endcase
			// Program setup empties every cache, so a late read shows garbage
			if (i_pins.io == 8'h80) held <= 1'b0;
			if (i_pins.io == 8'h30) held <= 1'b1;
		end
		if (wlat && i_pins.ale) begin
			na <= na + 1;
			if ((cmd == 8'h78 && na == 2) || na == 4) die <= i_pins.io[1];
			if (na == 1) colh <= i_pins.io;
			if (na == 3) row1 <= i_pins.io;
		end
	end
	// Per-die readiness and the shared busy line
	always_comb begin
		for (int d = 0; d < 2; d++) begin
			rdy[d] = rcnt[d] == 0;
			array_ready_flag[d] = cnt[d] == 0;
		end
	end
	assign o_rb = &array_ready_flag;
	assign st = (cmd == 8'h78) ? {1'b0, rdy[die], array_ready_flag[die], i_ecc[2], i_ecc[1], 2'b00, i_ecc[0]}
		: {1'b0, &rdy, &array_ready_flag, i_ecc[2], i_ecc[1], 2'b00, i_ecc[0]};
	// Released bus shows a moving pattern, never a stale byte
	always_comb begin
		if (i_pins.ce_b || i_pins.re_b) o_io = tog;
		else if (cmd == 8'h70 || cmd == 8'h78) o_io = st;
		else if (!held) o_io = tog;
		else if (colh == 8'h08 && row1 == 8'hA5) o_io = 8'h00;
		else o_io = 8'hFF;
	end
endmodule // nmds_nand_model

//--- dv/nmds_host_tb.sv
// Self-checking bench for the multi-die NAND host sequencer
`include "nmds_consts.svh"
module nmds_host_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk, i_rst_b, awv, awr, wv, wrdy, bv, bry, arv, arr, rv, rry, rb;
	logic [7:0] awa, ara, nio, sb;
	logic [31:0] wd, rdat, s, f, row0;
	logic [1:0] bresp, rresp, rsp, wrsp;
	logic [2:0] ecc;
	nmds_pkg::nmds_pins_s pins;
	int n_mismatch = 0;
	int num_checks = 0;
	int cyc = 0;
	logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6};
	logic [31:0] tpd [3] = '{32'h0, 32'h41, 32'h40};
	logic [31:0] rows [2];
	nmds_host #(.DIES(2), .NBAD(4)) dut (
		.i_clk(i_clk), .i_rst_b(i_rst_b),
		.i_awvalid(awv), .o_awready(awr), .i_awaddr(awa),
		.i_wvalid(wv), .o_wready(wrdy), .i_wdata(wd), .i_wstrb(4'hF),
		.o_bvalid(bv), .i_bready(bry), .o_bresp(bresp),
		.i_arvalid(arv), .o_arready(arr), .i_araddr(ara),
		.o_rvalid(rv), .i_rready(rry), .o_rdata(rdat), .o_rresp(rresp),
		.o_pins(pins), .i_io(nio), .i_rb(rb));
	nmds_nand_model #(.BUSY(400)) u_nand (
		.i_clk(i_clk), .i_pins(pins), .i_ecc(ecc), .o_io(nio), .o_rb(rb));
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	// Hang guard, well above the few thousand cycles the tests take
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_mismatch++;
			test_done();
		end
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] mkrow(input logic d, input logic [10:0] b, input logic [5:0] p);
		return {14'h0, d, b, p};
	endfunction
	function automatic logic [7:0] sbyte(input logic r, input logic a, input logic [2:0] e);
		return {1'b0, r, a, e[2], e[1], 2'b00, e[0]};
	endfunction
	function automatic logic [2:0] eflag(input logic [2:0] e);
		return {e == 3'h1, e == 3'h6, e == 3'h2};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awv <= 1'b1;
		wv <= 1'b1;
		awa <= a;
		wd <= d;
		bry <= 1'b1;
		@(negedge i_clk);
		while (awr !== 1'b1) @(negedge i_clk);
		@(posedge i_clk);
		awv <= 1'b0;
		wv <= 1'b0;
		@(negedge i_clk);
		while (bv !== 1'b1) @(negedge i_clk);
		wrsp = bresp;
		@(posedge i_clk);
		bry <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		arv <= 1'b1;
		ara <= a;
		rry <= 1'b1;
		@(negedge i_clk);
		while (arr !== 1'b1) @(negedge i_clk);
		@(posedge i_clk);
		arv <= 1'b0;
		@(negedge i_clk);
		while (rv !== 1'b1) @(negedge i_clk);
		d = rdat;
		r = rresp;
		@(posedge i_clk);
		rry <= 1'b0;
		@(posedge i_clk);
	endtask
	// One pin cycle, then wait until the engine is idle again
	task automatic op(input logic [1:0] k, input logic [7:0] v, input logic [2:0] fl);
		logic [31:0] t;
		wr(`NMDS_OFS_CTRL, {19'h0, fl, k, v});
		do rd(`NMDS_OFS_STAT, t, rsp);
		while (t[0] !== 1'b0);
	endtask
	task automatic seq(input logic [7:0] c0, input logic [31:0] r, input logic [7:0] c1,
		input logic [2:0] fl);
		logic [39:0] a;
		a = {r[23:0], 16'h0800};
		wr(`NMDS_OFS_ROW, r);
		op(0, c0, 3'h0);
		for (int i = 0; i < 5; i++) op(1, a[8 * i +: 8], 3'h0);
		op(0, c1, fl);
	endtask
	task automatic poll(input logic d, output logic [7:0] b);
		logic [31:0] r;
		r = mkrow(d, 11'h0, 6'h0);
		wr(`NMDS_OFS_ROW, r);
		op(0, 8'h78, 3'h0);
		for (int i = 0; i < 3; i++) op(1, r[8 * i +: 8], 3'h0);
		op(3, 8'h00, 3'h0);
		rd(`NMDS_OFS_RDAT, r, rsp);
		b = r[7:0];
	endtask
	task automatic get_flag(output logic [31:0] v);
		rd(`NMDS_OFS_FLAG, v, rsp);
		wr(`NMDS_OFS_FLAG, 32'h1F);
	endtask
	task automatic wait_rb();
		do rd(`NMDS_OFS_STAT, s, rsp);
		while (s[4] !== 1'b1);
		// Die flags follow the synced pin a cycle later, so read once more
		rd(`NMDS_OFS_STAT, s, rsp);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{i_rst_b, awv, wv, bry, arv, rry} = 6'h0;
		{awa, ara, wd, ecc} = 51'h0;
		void'($urandom(4635));
		repeat (8) @(posedge i_clk);
		i_rst_b <= 1'b1;
		@(posedge i_clk);
		check(32'(pins), 32'h2600);
		rd(`NMDS_OFS_STAT, s, rsp);
		check(32'({s[17:16], s[9:8], s[1]}), 32'h1);
		rd(`NMDS_OFS_FLAG, s, rsp);
		check(s, 32'h0);
		rd(8'h20, s, rsp);
		check(32'(rsp), 32'h2);
		wr(8'h24, 32'h0);
		check(32'(wrsp), 32'h2);
		$display("test reset done");
		// Poll shows one die ready while the other still initialises
		op(0, 8'hFF, 3'h0);
		do poll(1'b0, sb);
		while (sb[6] !== 1'b1);
		rd(`NMDS_OFS_STAT, s, rsp);
		check(32'(s[4]), 32'h0);
		row0 = mkrow(1'b0, 11'($urandom_range(0, 659)), 6'($urandom));
		seq(8'h80, row0, 8'h10, 3'h0);
		get_flag(f);
		check(32'(f[0]), 32'h1);
		wait_rb();
		check(32'({s[17:16], s[9:8]}), 32'hF);
		$display("test init done");
		foreach (codes[i]) begin
			ecc <= codes[i];
			op(0, 8'h70, 3'h0);
			op(3, 8'h00, 3'h0);
			rd(`NMDS_OFS_RDAT, s, rsp);
			check(32'(s[7:0]), 32'(sbyte(1'b1, 1'b1, codes[i])));
			get_flag(f);
			check(32'(f[3:1]), 32'(eflag(codes[i])));
		end
		ecc <= 3'h0;
		$display("test ecc done");
		// Cache program on die 0, then die 1 while die 0 works
		seq(8'h80, row0, 8'h15, 3'h0);
		seq(8'h80, row0 | 32'h20000, 8'h10, 3'h0);
		get_flag(f);
		check(32'(f[0]), 32'h0);
		seq(8'h80, row0, 8'h10, 3'h0);
		get_flag(f);
		check(32'(f[0]), 32'h1);
		op(0, 8'h70, 3'h0);
		get_flag(f);
		check(32'(f[0]), 32'h1);
		poll(1'b0, sb);
		check(32'(sb[6:5]), 32'h2);
		rd(`NMDS_OFS_STAT, s, rsp);
		check(32'({s[16], s[8]}), 32'h1);
		do poll(1'b0, sb);
		while (sb[5] !== 1'b1);
		rd(`NMDS_OFS_STAT, s, rsp);
		check(32'(s[16]), 32'h1);
		wait_rb();
		$display("test interleave done");
		foreach (tpd[i]) begin
			wr(`NMDS_OFS_ROW2, row0 ^ tpd[i]);
			seq(8'h80, row0, 8'h10, 3'h4);
			get_flag(f);
			check(32'(f[0]), 32'(!(tpd[i][6] && tpd[i][5:0] == 6'h0)));
			wait_rb();
		end
		$display("test two-plane done");
		rows[0] = row0;
		rows[1] = mkrow(1'b0, 11'h294, 6'($urandom));
		for (int j = 0; j < 2; j++) begin
			seq(8'h00, rows[j], 8'h30, 3'h0);
			op(0, 8'h80, 3'h0);
			get_flag(f);
			check(32'(f[0]), 32'h1);
			wait_rb();
			op(3, 8'h00, 3'h3);
			rd(`NMDS_OFS_RDAT, s, rsp);
			check(32'(s[7:0]), j ? 32'h0 : 32'hFF);
			get_flag(f);
			check(32'(f[4]), 32'(j));
			seq(8'h80, rows[j], 8'h10, 3'h0);
			get_flag(f);
			check(32'(f[0]), 32'(j));
			wait_rb();
		end
		$display("test bad block done");
		test_done();
	end
endmodule // nmds_host_tb
